// *** rtl/monitor_flash_security_gate.sv ***
/*
 * Security gate between monitor serial link, CPU flash accesses and
 * flash erase. Assumes rst is the power-on reset, sys_rst any other
 * reset, and that the flash lookup port answers in the same cycle as
 * the address.
 */
// Function
// - Wait eight bytes, compare with stored bytes
// - Match unlocks flash reads and fetches
// - Unlock survives non power-on resets
// - Locked flash reads return invalid value
// - Locked flash fetch raises illegal address reset
// - Break only after eighth byte
// - Set RAM 50 bit 6 on match
// - Locked still allows monitor and RAM code
// - Locked without keyword allows bulk erase
// - Recognise eight byte keyword at FFC0
// - Keyword and failure silence link after break
// - Keyword blocks erase without match from the second ST_RECV cycle on
// - Baud from select pin during reset
`timescale 1ns/10ps
`default_nettype none
module monitor_flash_security_gate #(
    parameter int          BIT_CYC_SLOW = sec_gate_pkg::BIT_CYC_SLOW,
    parameter int          BIT_CYC_FAST = sec_gate_pkg::BIT_CYC_FAST,
    // Keyword value is arbitrary
    parameter logic [63:0] KEYWORD      = 64'h4B45595741524400
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   sys_rst,
    input  wire logic                   monitor_serial_pin_in,
    output var  logic                   monitor_serial_pin_out,
    output var  logic                   monitor_serial_pin_oe,
    input  wire logic                   baud_select_pin,
    input  wire logic                   mon_tx_out,
    input  wire logic                   mon_tx_oe,
    output var  logic                   mon_rx_level,
    output var  logic                   link_active,
    output var  logic [15:0]            lookup_addr,
    input  wire logic [7:0]             lookup_data,
    input  wire sec_gate_pkg::cpu_req_s cpu_req,
    input  wire logic [7:0]             flash_rdata,
    output var  sec_gate_pkg::cpu_resp_s cpu_resp,
    output var  logic                   illegal_addr_reset,
    input  wire logic                   erase_req,
    output var  logic                   erase_grant,
    output var  logic                   erase_refuse,
    output var  sec_gate_pkg::ram_wr_s  ram_wr,
    output var  logic                   unlocked,
    output var  logic                   entry_done
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic in_flash(input logic [15:0] a);
        in_flash = (a >= sec_gate_pkg::FLASH_LO) && (a <= sec_gate_pkg::FLASH_HI);
    endfunction

    localparam int TMR_W_L = sec_gate_pkg::TMR_W;
    localparam int BREAK_BITS_L = sec_gate_pkg::BREAK_BITS;
    localparam logic [TMR_W_L-1:0] BIT_SLOW = TMR_W_L'(BIT_CYC_SLOW);
    localparam logic [TMR_W_L-1:0] BIT_FAST = TMR_W_L'(BIT_CYC_FAST);

    // ------------------------------------------------------------------
    // Pin synchronisers and baud strap
    // ------------------------------------------------------------------
    logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
    logic bs_s1_reg, bs_s2_reg;
    logic baud_slow_reg, baud_slow_next;

    always_comb begin
        baud_slow_next = rst ? bs_s2_reg : baud_slow_reg;
    end

    always_ff @(posedge ref_clk) begin
        rx_s1_reg     <= monitor_serial_pin_in;
        rx_s2_reg     <= rx_s1_reg;
        rx_s3_reg     <= rx_s2_reg;
        bs_s1_reg     <= baud_select_pin;
        bs_s2_reg     <= bs_s1_reg;
        baud_slow_reg <= baud_slow_next;
    end

    logic [TMR_W_L-1:0] bit_cyc;
    assign bit_cyc = baud_slow_reg ? BIT_SLOW : BIT_FAST;

    // ------------------------------------------------------------------
    // Entry sequence state
    // ------------------------------------------------------------------
    sec_gate_pkg::gate_state_e state_reg, state_next;
    logic [7:0]         pwd_reg  [sec_gate_pkg::NUM_BYTES];
    logic [7:0]         pwd_next [sec_gate_pkg::NUM_BYTES];
    logic [7:0]         key_reg  [sec_gate_pkg::NUM_BYTES];
    logic [7:0]         key_next [sec_gate_pkg::NUM_BYTES];
    logic [4:0]         fidx_reg, fidx_next;
    logic [15:0]        laddr_reg, laddr_next;
    logic [3:0]         bidx_reg, bidx_next;
    logic               miss_reg, miss_next;
    logic               unl_reg, unl_next;
    logic               silent_reg, silent_next;
    logic               keyok_reg, keyok_next;
    logic               rx_busy_reg, rx_busy_next;
    logic [3:0]         rx_bit_reg, rx_bit_next;
    logic [7:0]         rx_sh_reg, rx_sh_next;
    logic [TMR_W_L-1:0] tmr_reg, tmr_next;
    logic               pin_out_reg, pin_out_next;
    logic               pin_oe_reg, pin_oe_next;
    logic               mrx_reg, mrx_next;
    sec_gate_pkg::ram_wr_s ram_reg, ram_next;
    logic               byte_done;
    logic [63:0]        key_flat;
    logic [2:0]         cap_idx;

    always_comb begin
        state_next   = state_reg;
        pwd_next     = pwd_reg;
        key_next     = key_reg;
        fidx_next    = fidx_reg;
        laddr_next   = laddr_reg;
        bidx_next    = bidx_reg;
        miss_next    = miss_reg;
        unl_next     = unl_reg;
        silent_next  = silent_reg;
        keyok_next   = keyok_reg;
        rx_busy_next = rx_busy_reg;
        rx_bit_next  = rx_bit_reg;
        rx_sh_next   = rx_sh_reg;
        tmr_next     = tmr_reg;
        pin_out_next = 1'b1;
        pin_oe_next  = 1'b0;
        ram_next     = '0;
        byte_done    = 1'b0;
        cap_idx      = 3'(fidx_reg - 5'd1);
        key_flat     = '0;
        for (int i = 0; i < sec_gate_pkg::NUM_BYTES; i++) begin
            key_flat[63-8*i -: 8] = key_reg[i];
        end
        mrx_next     = (state_reg == sec_gate_pkg::ST_DONE) && !silent_reg ? rx_s3_reg : 1'b1;

        case (state_reg)
            sec_gate_pkg::ST_FETCH: begin
                // Read stored password then keyword bytes
                if (fidx_reg < 5'd8) begin
                    laddr_next = sec_gate_pkg::PWD_BASE + 16'(fidx_reg);
                end else begin
                    laddr_next = sec_gate_pkg::KEY_BASE + 16'(fidx_reg - 5'd8);
                end
                if (fidx_reg >= 5'd1 && fidx_reg <= 5'd8) begin
                    pwd_next[cap_idx] = lookup_data;
                end
                if (fidx_reg >= 5'd9) begin
                    key_next[cap_idx] = lookup_data;
                end
                fidx_next = fidx_reg + 5'd1;
                if (fidx_reg == 5'd16) begin
                    state_next = sec_gate_pkg::ST_RECV;
                end
            end
            sec_gate_pkg::ST_RECV: begin
                keyok_next = (key_flat == KEYWORD);
                if (!rx_busy_reg) begin
                    if (rx_s3_reg && !rx_s2_reg) begin
                        rx_busy_next = 1'b1;
                        rx_bit_next  = 4'd0;
                        tmr_next     = bit_cyc >> 1;
                    end
                end else if (tmr_reg != '0) begin
                    tmr_next = tmr_reg - 1'b1;
                end else begin
                    tmr_next    = bit_cyc - 1'b1;
                    rx_bit_next = rx_bit_reg + 4'd1;
                    if (rx_bit_reg == 4'd0) begin
                        rx_busy_next = !rx_s3_reg;
                    end else if (rx_bit_reg <= 4'd8) begin
                        rx_sh_next = {rx_s3_reg, rx_sh_reg[7:1]};
                    end else begin
                        rx_busy_next = 1'b0;
                        byte_done    = rx_s3_reg;
                    end
                end
                if (byte_done) begin
                    // Every position counts
                    if (rx_sh_reg != pwd_reg[bidx_reg[2:0]]) begin
                        miss_next = 1'b1;
                    end
                    bidx_next = bidx_reg + 4'd1;
                    if (bidx_reg == 4'd7) begin
                        state_next = sec_gate_pkg::ST_BREAK;
                        // Pin goes low one cycle later, so no minus one
                        tmr_next   = TMR_W_L'(bit_cyc * BREAK_BITS_L);
                    end
                end
            end
            sec_gate_pkg::ST_BREAK: begin
                pin_out_next = 1'b0;
                pin_oe_next  = 1'b1;
                tmr_next     = tmr_reg - 1'b1;
                if (tmr_reg == '0) begin
                    pin_oe_next = 1'b0;
                    state_next  = sec_gate_pkg::ST_DONE;
                    unl_next    = !miss_reg;
                    silent_next = miss_reg && keyok_reg;
                    if (!miss_reg) begin
                        ram_next.valid = 1'b1;
                        ram_next.addr  = sec_gate_pkg::RAM_FLAG_ADDR;
                        ram_next.data  = sec_gate_pkg::RAM_FLAG_DATA;
                    end
                end
            end
            default: begin
                // Monitor owns the link unless silenced
                if (!silent_reg) begin
                    pin_out_next = mon_tx_out;
                    pin_oe_next  = mon_tx_oe;
                end
            end
        endcase

        if (sys_rst && !(state_reg inside {sec_gate_pkg::ST_DONE, sec_gate_pkg::ST_FETCH})) begin
            state_next   = sec_gate_pkg::ST_RECV;
            bidx_next    = 4'd0;
            miss_next    = 1'b0;
            rx_busy_next = 1'b0;
            pin_oe_next  = 1'b0;
        end else if (sys_rst) begin
            pin_oe_next  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg   <= sec_gate_pkg::ST_FETCH;
            for (int i = 0; i < sec_gate_pkg::NUM_BYTES; i++) begin
                pwd_reg[i] <= 8'h00;
                key_reg[i] <= 8'h00;
            end
            fidx_reg    <= 5'h00;
            laddr_reg   <= 16'h0000;
            bidx_reg    <= 4'h0;
            miss_reg    <= 1'b0;
            unl_reg     <= 1'b0;
            silent_reg  <= 1'b0;
            keyok_reg   <= 1'b0;
            rx_busy_reg <= 1'b0;
            rx_bit_reg  <= 4'h0;
            rx_sh_reg   <= 8'h00;
            tmr_reg     <= '0;
            pin_out_reg <= 1'b1;
            pin_oe_reg  <= 1'b0;
            mrx_reg     <= 1'b1;
            ram_reg     <= '0;
        end else begin
            state_reg   <= state_next;
            pwd_reg     <= pwd_next;
            key_reg     <= key_next;
            fidx_reg    <= fidx_next;
            laddr_reg   <= laddr_next;
            bidx_reg    <= bidx_next;
            miss_reg    <= miss_next;
            unl_reg     <= unl_next;
            silent_reg  <= silent_next;
            keyok_reg   <= keyok_next;
            rx_busy_reg <= rx_busy_next;
            rx_bit_reg  <= rx_bit_next;
            rx_sh_reg   <= rx_sh_next;
            tmr_reg     <= tmr_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg  <= pin_oe_next;
            mrx_reg     <= mrx_next;
            ram_reg     <= ram_next;
        end
    end

    // ------------------------------------------------------------------
    // CPU access and erase gating
    // ------------------------------------------------------------------
    sec_gate_pkg::cpu_resp_s resp_reg, resp_next;
    logic ill_reg, ill_next;
    logic egr_reg, egr_next;
    logic erf_reg, erf_next;
    logic flash_hit;

    always_comb begin
        flash_hit       = in_flash(cpu_req.addr);
        resp_next.valid = cpu_req.valid && !sys_rst;
        resp_next.data  = flash_rdata;
        ill_next        = 1'b0;
        if (flash_hit && !unl_reg) begin
            resp_next.data = sec_gate_pkg::INVALID_DATA;
            if (cpu_req.valid && cpu_req.fetch && !sys_rst) begin
                resp_next.valid = 1'b0;
                ill_next        = 1'b1;
            end
        end
        // RAM accesses pass through unless sys_rst is high
        egr_next = 1'b0;
        erf_next = 1'b0;
        if (erase_req && !sys_rst) begin
            if (unl_reg || !keyok_reg) begin
                egr_next = 1'b1;
            end else begin
                erf_next = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resp_reg <= '0;
            ill_reg  <= 1'b0;
            egr_reg  <= 1'b0;
            erf_reg  <= 1'b0;
        end else begin
            resp_reg <= resp_next;
            ill_reg  <= ill_next;
            egr_reg  <= egr_next;
            erf_reg  <= erf_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign monitor_serial_pin_out = pin_out_reg;
    assign monitor_serial_pin_oe  = pin_oe_reg;
    assign mon_rx_level           = mrx_reg;
    assign link_active            = (state_reg == sec_gate_pkg::ST_DONE) && !silent_reg;
    assign lookup_addr            = laddr_reg;
    assign cpu_resp               = resp_reg;
    assign illegal_addr_reset     = ill_reg;
    assign erase_grant            = egr_reg;
    assign erase_refuse           = erf_reg;
    assign ram_wr                 = ram_reg;
    assign unlocked               = unl_reg;
    assign entry_done             = (state_reg == sec_gate_pkg::ST_DONE);
endmodule
`default_nettype wire

// *** shared/sec_gate_pkg.sv ***
/*
 * Constants and carrier types for the monitor flash security gate.
 * Assumes a single 100 MHz bus clock shared by every user of this package.
 */
`default_nettype none
package sec_gate_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ        = 100_000_000;
    localparam int BAUD_SLOW     = 4800;
    localparam int BAUD_FAST     = 9600;
    localparam int BIT_CYC_SLOW  = CLK_HZ / BAUD_SLOW;
    localparam int BIT_CYC_FAST  = CLK_HZ / BAUD_FAST;
    localparam int BREAK_BITS    = 10;
    localparam int TMR_W         = 18;
    // ------------------------------------------------------------------
    // Memory layout
    // ------------------------------------------------------------------
    localparam int          NUM_BYTES     = 8;
    localparam logic [15:0] PWD_BASE      = 16'hFFF6;
    localparam logic [15:0] KEY_BASE      = 16'hFFC0;
    localparam logic [15:0] FLASH_LO      = 16'h8000;
    localparam logic [15:0] FLASH_HI      = 16'hFFFF;
    localparam logic [7:0]  RAM_FLAG_ADDR = 8'h50;
    localparam int          RAM_FLAG_BIT  = 6;
    localparam logic [7:0]  RAM_FLAG_DATA = 8'h40;
    localparam logic [7:0]  INVALID_DATA  = 8'hFF;
    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic [15:0] addr;
    } cpu_req_s;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } cpu_resp_s;
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } ram_wr_s;
    typedef enum logic [1:0] {ST_FETCH, ST_RECV, ST_BREAK, ST_DONE} gate_state_e;
endpackage
`default_nettype wire

// *** bench/sec_gate_monitor.sv ***
/*
 * Concurrent checks on the ports of the monitor flash security gate.
 * Assumes one clock, rst as power-on reset, and a bench with no sys_rst near CPU requests.
 */
`timescale 1ns/10ps
`default_nettype none
module sec_gate_monitor #(
    parameter int BIT_CYC_SLOW = 16,
    parameter int BIT_CYC_FAST = 8
) (
    input wire logic                    ref_clk,
    input wire logic                    rst,
    input wire logic                    sys_rst,
    input wire logic                    baud_select_pin,
    input wire logic                    monitor_serial_pin_out,
    input wire logic                    monitor_serial_pin_oe,
    input wire logic                    mon_rx_level,
    input wire logic                    link_active,
    input wire sec_gate_pkg::cpu_req_s  cpu_req,
    input wire logic [7:0]              flash_rdata,
    input wire sec_gate_pkg::cpu_resp_s cpu_resp,
    input wire logic                    illegal_addr_reset,
    input wire logic                    erase_req,
    input wire logic                    erase_grant,
    input wire logic                    erase_refuse,
    input wire sec_gate_pkg::ram_wr_s   ram_wr,
    input wire logic                    unlocked,
    input wire logic                    entry_done
);
    // ------------------------------------------------------------------
    // Break length counter
    // ------------------------------------------------------------------
    int   brk_cnt_reg;
    int   brk_cnt_next;
    logic slow_reg;
    logic slow_next;
    always_comb begin
        slow_next = rst ? baud_select_pin : slow_reg;
        brk_cnt_next = rst ? 0 : brk_cnt_reg + ((monitor_serial_pin_oe && !entry_done) ? 1 : 0);
    end
    always_ff @(posedge ref_clk) begin
        slow_reg <= slow_next;
        brk_cnt_reg <= brk_cnt_next;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    break_len_a: assert property ($rose(entry_done) |-> brk_cnt_reg ==
        sec_gate_pkg::BREAK_BITS * (slow_reg ? BIT_CYC_SLOW : BIT_CYC_FAST))
        else $error("break length wrong");
    break_low_a: assert property (monitor_serial_pin_oe && !entry_done |->
        !monitor_serial_pin_out) else $error("break not low");
    link_silent_a: assert property ($past(entry_done) && !link_active |->
        !monitor_serial_pin_oe && mon_rx_level) else $error("silenced link drives");
    ram_flag_a: assert property (ram_wr.valid |-> ram_wr.addr == sec_gate_pkg::RAM_FLAG_ADDR
        && ram_wr.data == sec_gate_pkg::RAM_FLAG_DATA ##1 !ram_wr.valid && unlocked)
        else $error("flag write wrong");
    unlock_hold_a: assert property ($fell(unlocked) |-> $past(rst))
        else $error("unlock lost without power-on reset");
    locked_read_a: assert property (cpu_req.valid && !cpu_req.fetch && !unlocked && !sys_rst
        && cpu_req.addr >= sec_gate_pkg::FLASH_LO |=> cpu_resp.valid
        && cpu_resp.data == sec_gate_pkg::INVALID_DATA) else $error("locked read leaks");
    ram_access_a: assert property (cpu_req.valid && !unlocked && !sys_rst
        && cpu_req.addr < sec_gate_pkg::FLASH_LO |=> cpu_resp.valid && !illegal_addr_reset
        && cpu_resp.data == $past(flash_rdata)) else $error("RAM access blocked");
    illegal_fetch_a: assert property (cpu_req.valid && cpu_req.fetch && !unlocked && !sys_rst
        && cpu_req.addr >= sec_gate_pkg::FLASH_LO |=> illegal_addr_reset && !cpu_resp.valid)
        else $error("locked fetch not trapped");
    open_access_a: assert property (cpu_req.valid && unlocked && !sys_rst |=>
        cpu_resp.valid && !illegal_addr_reset && cpu_resp.data == $past(flash_rdata))
        else $error("unlocked access wrong");
    erase_answer_a: assert property (erase_req && !sys_rst |=> erase_grant ^ erase_refuse)
        else $error("erase not answered once");
    erase_open_a: assert property (erase_req && unlocked && !sys_rst |=> erase_grant)
        else $error("erase refused while unlocked");
endmodule
bind monitor_flash_security_gate sec_gate_monitor #(
    .BIT_CYC_SLOW(BIT_CYC_SLOW), .BIT_CYC_FAST(BIT_CYC_FAST)
) sec_gate_monitor_i (
    .ref_clk(ref_clk), .rst(rst), .sys_rst(sys_rst), .baud_select_pin(baud_select_pin),
    .monitor_serial_pin_out(monitor_serial_pin_out), .monitor_serial_pin_oe(monitor_serial_pin_oe),
    .mon_rx_level(mon_rx_level), .link_active(link_active), .cpu_req(cpu_req),
    .flash_rdata(flash_rdata), .cpu_resp(cpu_resp), .illegal_addr_reset(illegal_addr_reset),
    .erase_req(erase_req), .erase_grant(erase_grant), .erase_refuse(erase_refuse),
    .ram_wr(ram_wr), .unlocked(unlocked), .entry_done(entry_done)
);
`default_nettype wire

// *** bench/sec_host_model.sv ***
/*
 * Host side of the monitor serial link: sends 8N1 frames, LSB first.
 * Assumes the bench resolves the pin from this line and the gate's drive.
 */
`timescale 1ns/10ps
`default_nettype none
module sec_host_model (
    input  wire logic ref_clk,
    output var  logic host_line
);
    initial host_line = 1'b1;
    // Frame of start, data LSB first, stop; nc cycles per bit
    task automatic send(input logic [7:0] b, input int nc);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_line = fr[i];
            repeat (nc) begin
                @(posedge ref_clk);
                #1;
            end
        end
    endtask
endmodule
`default_nettype wire

// *** bench/test_monitor_flash_security_gate.sv ***
/*
 * Self-checking bench for the monitor flash security gate.
 * Assumes shortened bit times of 8 and 16 cycles and a bench flash model.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 3000) begin tick(); k++; end \
    if (k == 3000) begin n_mismatch++; end_sim(); end end
module test_monitor_flash_security_gate;
    // Keyword value is arbitrary
    localparam logic [63:0] KEY = 64'h474154454B455900;
    typedef struct {logic fetch; logic [15:0] addr; logic [7:0] rd; logic lv; logic [7:0] ld;} row_s;
    row_s rows [4] = '{'{0, 16'h0050, 8'h12, 1, 8'h12}, '{0, 16'h9000, 8'h34, 1, 8'hFF},
                       '{1, 16'hFFF6, 8'h56, 0, 8'h56}, '{1, 16'h0100, 8'h78, 1, 8'h78}};
    logic ref_clk, rst, sys_rst, baud_select_pin, mon_tx_out, mon_tx_oe, erase_req, key_on;
    logic pin_out, pin_oe, host_line, mon_rx_level, link_active, illegal_addr_reset;
    logic erase_grant, erase_refuse, unlocked, entry_done;
    logic [15:0] lookup_addr;
    logic [7:0] lookup_data, flash_rdata;
    sec_gate_pkg::cpu_req_s cpu_req;
    sec_gate_pkg::cpu_resp_s cpu_resp;
    sec_gate_pkg::ram_wr_s ram_wr;
    int n_mismatch = 0, n_checks = 0, k, ram_cnt = 0;
    wire logic pin_level = pin_oe ? pin_out : host_line;
    monitor_flash_security_gate #(.BIT_CYC_SLOW(16), .BIT_CYC_FAST(8), .KEYWORD(KEY))
        monitor_flash_security_gate_i (.ref_clk(ref_clk), .rst(rst), .sys_rst(sys_rst),
        .monitor_serial_pin_in(pin_level), .monitor_serial_pin_out(pin_out),
        .monitor_serial_pin_oe(pin_oe), .baud_select_pin(baud_select_pin),
        .mon_tx_out(mon_tx_out), .mon_tx_oe(mon_tx_oe), .mon_rx_level(mon_rx_level),
        .link_active(link_active), .lookup_addr(lookup_addr), .lookup_data(lookup_data),
        .cpu_req(cpu_req), .flash_rdata(flash_rdata), .cpu_resp(cpu_resp),
        .illegal_addr_reset(illegal_addr_reset), .erase_req(erase_req),
        .erase_grant(erase_grant), .erase_refuse(erase_refuse), .ram_wr(ram_wr),
        .unlocked(unlocked), .entry_done(entry_done));
    sec_host_model sec_host_model_i (.ref_clk(ref_clk), .host_line(host_line));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------------
    // Flash model: password bytes and optional keyword
    // ------------------------------------------------------------------
    function automatic logic [7:0] stored(input logic [15:0] a);
        if (a >= sec_gate_pkg::PWD_BASE && a < sec_gate_pkg::PWD_BASE + 16'h0008)
            return 8'hA0 + 8'(a - sec_gate_pkg::PWD_BASE);
        if (key_on && a >= sec_gate_pkg::KEY_BASE && a < sec_gate_pkg::KEY_BASE + 16'h0008)
            return 8'(KEY >> (56 - 8 * int'(a - sec_gate_pkg::KEY_BASE)));
        return 8'h00;
    endfunction
    // Stored byte answers within the cycle of its address
    always_comb lookup_data = stored(lookup_addr);
    always @(posedge ref_clk) begin
        if (ram_wr.valid === 1'b1) ram_cnt <= ram_cnt + 1;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task tick();
        @(posedge ref_clk);
        #1;
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task por(input logic key, input logic sel);
        rst = 1'b1;
        key_on = key;
        baud_select_pin = sel;
        repeat (16) tick();
        `CHK(unlocked, 1'b0)
        `CHK(pin_oe, 1'b0)
        rst = 1'b0;
        repeat (20) tick();
    endtask
    task entry(input int pos, input logic [7:0] flip, input int nc);
        int n0;
        n0 = ram_cnt;
        for (int i = 0; i < 8; i++) begin
            if (i == 7) `CHK(pin_oe, 1'b0)
            sec_host_model_i.send(8'hA0 + 8'(i) ^ (i == pos ? flip : 8'h00), nc);
        end
        `WAIT(pin_oe === 1'b1)
        `CHK(pin_out, 1'b0)
        `WAIT(entry_done === 1'b1)
        repeat (2) tick();
        `CHK(unlocked, flip == 8'h00)
        `CHK(ram_cnt - n0, (flip == 8'h00) ? 1 : 0)
    endtask
    task run_rows(input logic u);
        for (int i = 0; i < 4; i++) begin
            cpu_req = '{1'b1, rows[i].fetch, rows[i].addr};
            flash_rdata = rows[i].rd;
            tick();
            `CHK(cpu_resp.valid, u ? 1'b1 : rows[i].lv)
            `CHK(illegal_addr_reset, u ? 1'b0 : !rows[i].lv)
            if (u || rows[i].lv) `CHK(cpu_resp.data, u ? rows[i].rd : rows[i].ld)
        end
        cpu_req = '0;
    endtask
    task erase(input logic g);
        erase_req = 1'b1;
        tick();
        erase_req = 1'b0;
        `CHK(erase_grant, g)
        `CHK(erase_refuse, !g)
    endtask
    task drive_tx(input logic oe, input logic exp_oe, input logic exp_rx);
        mon_tx_oe = oe;
        mon_tx_out = 1'b0;
        repeat (8) tick();
        `CHK(pin_oe, exp_oe)
        `CHK(mon_rx_level, exp_rx)
        mon_tx_oe = 1'b0;
        repeat (8) tick();
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, sys_rst, baud_select_pin, mon_tx_oe, erase_req, key_on} = 6'b100000;
        mon_tx_out = 1'b1;
        cpu_req = '0;
        flash_rdata = 8'h00;
        por(1'b0, 1'b0);
        entry(0, 8'h01, 8);
        run_rows(1'b0);
        erase(1'b1);
        `CHK(link_active, 1'b1)
        por(1'b1, 1'b0);
        entry(7, 8'h80, 8);
        `CHK(link_active, 1'b0)
        fork
            sec_host_model_i.send(8'h00, 8);
            begin
                repeat (20) tick();
                `CHK(mon_rx_level, 1'b1)
            end
        join
        drive_tx(1'b1, 1'b0, 1'b1);
        erase(1'b0);
        por(1'b1, 1'b1);
        entry(9, 8'h00, 16);
        run_rows(1'b1);
        erase(1'b1);
        drive_tx(1'b1, 1'b1, 1'b0);
        sys_rst = 1'b1;
        tick();
        sys_rst = 1'b0;
        repeat (3) tick();
        `CHK(unlocked, 1'b1)
        `CHK(entry_done, 1'b1)
        run_rows(1'b1);
        por(1'b0, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
